// file: scc_core.sv
// Sync source choice, polarity, separator, clamp and coast timing, power mode controls.
// Assumes all pins are synchronous to clk_sys and the serial port delivers decoded subaddress accesses.
`timescale 1ns/100ps
module scc_core #(
   parameter int         ACT_WIN      = scc_pkg::ACT_WIN_TICKS,   // Activity window in reference ticks
   parameter logic [7:0] RST_LEAD     = 8'h01                     // Coast lead lines reset value
) (
   input  wire logic                          clk_sys,           // System clock 100 MHz
   input  wire logic                          nrst,              // Asynchronous reset, active low
   input  wire logic                          reg_wr,            // Register write strobe
   input  wire logic [7:0]                    reg_addr,          // Register subaddress
   input  wire logic [7:0]                    reg_wdata,         // Register write data
   output logic      [7:0]                    reg_rdata,         // Register read data
   input  wire logic                          hsync_in,          // Selected discrete horizontal sync
   input  wire logic                          vsync_in,          // Selected discrete vertical sync
   input  wire logic                          sog_in,            // Sliced green sync, active low
   input  wire logic                          coast_in,          // External coast pin
   input  wire logic                          clamp_in,          // External clamp pin
   input  wire logic                          clamp_int,         // Internally timed clamp pulse
   input  wire logic                          raw_bypass,        // Raw sync bypass mode
   input  wire logic [2:0]                    fine_clamp_off,    // Per channel fine clamp disable
   output logic                               hsync_out,         // Horizontal sync output
   output logic                               vsync_out,         // Vertical sync output
   output logic                               fine_clamp_pulse,  // Fine clamp and level timing
   output logic                               fine_clamp_en,     // Fine clamp enable
   output logic                               coarse_clamp_en,   // Coarse clamp enable
   output logic                               adc_ext_clk_sel,   // Converters on external clock
   output logic      [2:0]                    clamp_mid_level,   // Per channel mid level clamp
   output logic      [scc_pkg::SLICER_W-1:0]  slicer_threshold_code, // Green sync slicer code
   output logic                               pll_coast,         // Coast to horizontal PLL
   output logic                               pll_phase_update,  // PLL may track edges
   output logic                               pll_freq_hold,     // PLL holds frequency
   output logic                               low_power,         // Automatic low power state
   output logic                               full_power_down,   // Whole chip powered down
   output logic      [7:0]                    sync_status        // Sync detect status byte
);
   import scc_pkg::*;

   // Window counter must hold ACT_WIN and a half window must be nonzero
   if (ACT_WIN < 2 || ACT_WIN >= (1 << WIN_W)) begin : g_bad_win
      $error("scc_core: ACT_WIN out of range");
   end

   scc_state_t cur_ff;
   scc_state_t nxt_st;

   logic [7:0] r_sync;
   logic [7:0] r_pll;
   logic [7:0] r_slc;
   logic [7:0] r_sep;
   logic [7:0] r_lead;
   logic [7:0] r_trl;
   logic       ref_tick;
   logic       win_end;
   logic       h_src_sog;
   logic       v_src_sep;
   logic       hs_pol_high;
   logic       hs_norm;
   logic       vs_norm;
   logic       coast_pol_high;
   logic       coast_ext;
   logic       coast_sel;
   logic       sep_in;
   logic [NUM_IN-1:0] pins;
   logic [7:0] status;

   assign r_sync = cur_ff.regs[0];
   assign r_pll  = cur_ff.regs[1];
   assign r_slc  = cur_ff.regs[2];
   assign r_sep  = cur_ff.regs[3];
   assign r_lead = cur_ff.regs[4];
   assign r_trl  = cur_ff.regs[5];

   assign pins = {coast_in, sog_in, vsync_in, hsync_in};
   assign ref_tick = (cur_ff.div_cnt == DIV_W'(REF_DIV - 1));
   assign win_end  = ref_tick && (cur_ff.win_cnt == WIN_W'(ACT_WIN - 1));

   // Horizontal source choice
   always_comb begin
      if (r_sync[B_H_SRC_OVR]) begin
         h_src_sog = r_sync[B_H_SRC_SEL];                                 // RULE_06
      end else if (cur_ff.active[IN_HS]) begin
         h_src_sog = 1'b0;                                                // RULE_05
      end else begin
         h_src_sog = cur_ff.active[IN_SOG];                               // RULE_05
      end
   end

   // Vertical source choice; separator counts as active when green sync is
   always_comb begin
      if (r_sync[B_V_SRC_OVR]) begin
         v_src_sep = r_sync[B_V_SRC_SEL];                                 // RULE_09
      end else if (cur_ff.active[IN_VS]) begin
         v_src_sep = 1'b0;                                                // RULE_08
      end else begin
         v_src_sep = cur_ff.active[IN_SOG];                               // RULE_08
      end
   end

   assign hs_pol_high = r_sync[B_HS_POL_OVR] ? r_sync[B_HS_IN_POL]        // RULE_01
                                             : cur_ff.pol_high[IN_HS];    // RULE_01
   // Normalised syncs are active high internally
   assign hs_norm = h_src_sog ? ~sog_in                                   // RULE_07
                              : (hs_pol_high ? hsync_in : ~hsync_in);     // RULE_02
   assign vs_norm = v_src_sep ? cur_ff.sep_out
                              : (cur_ff.pol_high[IN_VS] ? vsync_in : ~vsync_in);
   assign sep_in  = ~sog_in;

   assign coast_pol_high = r_pll[B_COAST_POVR] ? r_pll[B_COAST_PVAL]      // RULE_14
                                               : cur_ff.pol_high[IN_COAST]; // RULE_14
   assign coast_ext = coast_pol_high ? coast_in : ~coast_in;
   assign coast_sel = r_pll[B_COAST_SEL] ? cur_ff.coast_int : coast_ext;  // RULE_13

   assign status = {cur_ff.active[IN_HS], h_src_sog, cur_ff.pol_high[IN_HS],
                    cur_ff.active[IN_VS], v_src_sep, cur_ff.pol_high[IN_VS],
                    cur_ff.active[IN_SOG], cur_ff.pol_high[IN_COAST]};    // RULE_23

   always_comb begin
      nxt_st = cur_ff;

      // Register writes; status is read only
      if (reg_wr) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            if (reg_addr == ADDR_SYNC_CTL + 8'(r)) begin
               nxt_st.regs[r] = reg_wdata;
            end
         end
      end
      case (reg_addr)
         ADDR_SYNC_CTL:   nxt_st.rdata = r_sync;
         ADDR_PLL_CLAMP:  nxt_st.rdata = r_pll;
         ADDR_SLICER:     nxt_st.rdata = r_slc;
         ADDR_SEP_THR:    nxt_st.rdata = r_sep;
         ADDR_COAST_LEAD: nxt_st.rdata = r_lead;
         ADDR_COAST_TRL:  nxt_st.rdata = r_trl;
         ADDR_STATUS:     nxt_st.rdata = status;
         default:         nxt_st.rdata = 8'h00;
      endcase

      // Reference clock enable
      nxt_st.div_cnt = ref_tick ? '0 : cur_ff.div_cnt + DIV_W'(1);
      if (ref_tick) begin
         nxt_st.win_cnt = win_end ? '0 : cur_ff.win_cnt + WIN_W'(1);
      end

      // Activity and polarity per input; an edge in the closing cycle is kept
      nxt_st.prev = pins;
      for (int i = 0; i < NUM_IN; i++) begin
         if (win_end) begin
            nxt_st.active[i]    = cur_ff.edge_seen[i] | (pins[i] ^ cur_ff.prev[i]);     // RULE_23
            nxt_st.edge_seen[i] = 1'b0;
            // Short high time means pulses are high
            nxt_st.pol_high[i]  = (cur_ff.hi_cnt[i] < WIN_W'(ACT_WIN / 2));
            nxt_st.hi_cnt[i]    = '0;
         end else begin
            if (pins[i] ^ cur_ff.prev[i]) begin
               nxt_st.edge_seen[i] = 1'b1;
            end
            if (ref_tick && pins[i]) begin
               nxt_st.hi_cnt[i] = cur_ff.hi_cnt[i] + WIN_W'(1);
            end
         end
      end

      // Separator: level must persist threshold ticks before output follows
      if (sep_in == cur_ff.sep_out) begin
         nxt_st.sep_cnt = 8'h00;
      end else if (ref_tick) begin
         if (cur_ff.sep_cnt + 8'h01 >= r_sep) begin
            nxt_st.sep_out = sep_in;                                      // RULE_20
            nxt_st.sep_cnt = 8'h00;
         end else begin
            nxt_st.sep_cnt = cur_ff.sep_cnt + 8'h01;                      // RULE_20
         end
      end

      // Internal coast from line counting
      nxt_st.hs_prev = hs_norm;
      nxt_st.vs_prev = vs_norm;
      if (vs_norm && !cur_ff.vs_prev) begin
         nxt_st.frame_lines = cur_ff.line_cnt;
         nxt_st.line_cnt    = '0;
         nxt_st.trailing    = 1'b0;
      end else if (hs_norm && !cur_ff.hs_prev) begin
         nxt_st.line_cnt = cur_ff.line_cnt + LINE_W'(1);
         // Lead predicted from last frame length; zero lead makes no coast
         if (r_lead != 8'h00 && cur_ff.frame_lines > LINE_W'(r_lead) &&
             cur_ff.line_cnt + LINE_W'(1) >= cur_ff.frame_lines - LINE_W'(r_lead)) begin
            nxt_st.coast_int = 1'b1;                                      // RULE_21
         end
         if (cur_ff.trailing) begin
            if (cur_ff.trail_cnt <= 8'h01) begin
               nxt_st.trailing  = 1'b0;
               nxt_st.coast_int = 1'b0;                                   // RULE_22
            end else begin
               nxt_st.trail_cnt = cur_ff.trail_cnt - 8'h01;
            end
         end
      end
      if (!vs_norm && cur_ff.vs_prev) begin
         nxt_st.trail_cnt = r_trl;                                        // RULE_22
         nxt_st.trailing  = (r_trl != 8'h00);
         if (r_trl == 8'h00) begin
            nxt_st.coast_int = 1'b0;
         end
      end

      // Registered outputs
      if (raw_bypass) begin
         nxt_st.hsync_out = hsync_in;                                     // RULE_04
      end else begin
         nxt_st.hsync_out = r_sync[B_HS_OUT_POL] ? hs_norm : ~hs_norm;    // RULE_03
      end
      nxt_st.vsync_out = r_sync[B_VS_OUT_POL] ? vs_norm : ~vs_norm;       // RULE_03
      if (r_pll[B_ADC_TEST]) begin
         nxt_st.clamp_out = 1'b0;                                         // RULE_17
      end else if (r_pll[B_CLAMP_SRC]) begin
         nxt_st.clamp_out = r_pll[B_CLAMP_POL] ? ~clamp_in : clamp_in;    // RULE_12
      end else begin
         nxt_st.clamp_out = clamp_int;                                    // RULE_11
      end
      nxt_st.coast_out = coast_sel;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cur_ff             <= '0;
         cur_ff.regs[0]     <= RST_SYNC_CTL;
         cur_ff.regs[1]     <= RST_PLL_CLAMP;
         cur_ff.regs[2]     <= RST_SLICER;                                // RULE_18
         cur_ff.regs[3]     <= RST_SEP_THR;
         cur_ff.regs[4]     <= RST_LEAD;
         cur_ff.regs[5]     <= RST_COAST_TRL;
         cur_ff.prev        <= '0;
         cur_ff.pol_high    <= '0;
         cur_ff.hsync_out   <= 1'b1;
         cur_ff.vsync_out   <= 1'b1;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // Clamp level per channel; a disabled fine clamp forces bottom level
   for (genvar ch = 0; ch < 3; ch++) begin : g_clamp_lvl
      assign clamp_mid_level[ch] = r_slc[ch] & ~fine_clamp_off[ch] & ~r_pll[B_ADC_TEST]; // RULE_19
   end

   assign reg_rdata             = cur_ff.rdata;
   assign hsync_out             = cur_ff.hsync_out;
   assign vsync_out             = cur_ff.vsync_out;
   assign fine_clamp_pulse      = cur_ff.clamp_out;
   assign fine_clamp_en         = ~r_pll[B_ADC_TEST];                     // RULE_17
   assign coarse_clamp_en       = r_pll[B_ADC_TEST];                      // RULE_17
   assign adc_ext_clk_sel       = r_pll[B_ADC_TEST];                      // RULE_17
   assign slicer_threshold_code = r_slc[SLICER_LSB +: SLICER_W];          // RULE_18
   assign pll_coast             = cur_ff.coast_out;
   assign pll_phase_update      = ~cur_ff.coast_out & r_pll[B_FULL_PD_N]; // RULE_24
   assign pll_freq_hold         = cur_ff.coast_out;                       // RULE_24
   // Outputs are not tri-stated here; that belongs to the output stage
   assign low_power             = ~r_pll[B_SEEK_OVR] &
                                  ~(cur_ff.active[IN_HS] | cur_ff.active[IN_SOG] | cur_ff.active[IN_VS]); // RULE_15
   // Register file stays clocked during power down, so contents survive
   assign full_power_down       = ~r_pll[B_FULL_PD_N];                    // RULE_16
   assign sync_status           = status;
endmodule : scc_core

// file: scc_pkg.sv
// Package for the sync, clamp and coast control bank: subaddresses, fields, resets, timing.
// Assumes a single 100 MHz system clock and an upstream serial control port decoder.
// Operation
// [RULE_01] Polarity override selects register bit, else detected
// [RULE_02] Input polarity bit: 1 high, 0 low
// [RULE_03] Output polarity bits: 0 active low, 1 high
// [RULE_04] Raw bypass ignores horizontal output polarity
// [RULE_05] Auto horizontal choice prefers discrete, reports status
// [RULE_06] Select bit honoured under override only
// [RULE_07] Select 0 discrete, 1 green sync
// [RULE_08] Auto vertical prefers discrete, reports status bit
// [RULE_09] Vertical override: 0 discrete, 1 separator
// [RULE_10] Host enables auto selection only for five-wire
// [RULE_11] Clamp function: 0 internal, 1 external pin
// [RULE_12] External clamp: 0 active high, 1 low
// [RULE_13] Coast select: 0 external pin, 1 internal
// [RULE_14] Coast polarity detected unless override bit set
// [RULE_15] Seek override 0: idle inputs mean low power
// [RULE_16] Power-down low: all off, registers kept
// [RULE_17] Test mode: no fine clamp, coarse, external clock
// [RULE_18] Five-bit slicer code, bits 7:3, reset 0Bh
// [RULE_19] Per channel clamp level, ignored when disabled
// [RULE_20] Separator toggles after threshold reference periods
// [RULE_21] Coast leads vertical edge by programmed lines
// [RULE_22] Coast trails vertical end by programmed lines
// [RULE_23] Activity flags for discrete and green sync
// [RULE_24] Coast freezes PLL phase, holds frequency
package scc_pkg;
   localparam logic [7:0] ADDR_SYNC_CTL   = 8'h0E;
   localparam logic [7:0] ADDR_PLL_CLAMP  = 8'h0F;
   localparam logic [7:0] ADDR_SLICER     = 8'h10;
   localparam logic [7:0] ADDR_SEP_THR    = 8'h11;
   localparam logic [7:0] ADDR_COAST_LEAD = 8'h12;
   localparam logic [7:0] ADDR_COAST_TRL  = 8'h13;
   localparam logic [7:0] ADDR_STATUS     = 8'h14;
   localparam int         NUM_REGS        = 6;

   localparam logic [7:0] RST_SYNC_CTL    = 8'h5B;
   localparam logic [7:0] RST_PLL_CLAMP   = 8'h2E;
   localparam logic [7:0] RST_SLICER      = 8'h5D;
   localparam logic [7:0] RST_SEP_THR     = 8'h20;
   localparam logic [7:0] RST_COAST_TRL   = 8'h00;

   // Sync source control fields
   localparam int B_HS_POL_OVR  = 7;
   localparam int B_HS_IN_POL   = 6;
   localparam int B_HS_OUT_POL  = 5;
   localparam int B_H_SRC_OVR   = 4;
   localparam int B_H_SRC_SEL   = 3;
   localparam int B_VS_OUT_POL  = 2;
   localparam int B_V_SRC_OVR   = 1;
   localparam int B_V_SRC_SEL   = 0;
   // PLL and clamp control fields
   localparam int B_CLAMP_SRC   = 7;
   localparam int B_CLAMP_POL   = 6;
   localparam int B_COAST_SEL   = 5;
   localparam int B_COAST_POVR  = 4;
   localparam int B_COAST_PVAL  = 3;
   localparam int B_SEEK_OVR    = 2;
   localparam int B_FULL_PD_N   = 1;
   localparam int B_ADC_TEST    = 0;
   // Slicer code field
   localparam int SLICER_LSB    = 3;
   localparam int SLICER_W      = 5;

   // Sync inputs watched by activity and polarity detectors
   localparam int IN_HS    = 0;
   localparam int IN_VS    = 1;
   localparam int IN_SOG   = 2;
   localparam int IN_COAST = 3;
   localparam int NUM_IN   = 4;

   // Timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int REF_PERIOD_NS   = 150;
   localparam int REF_DIV         = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACT_WIN_US      = 25000;
   localparam int ACT_WIN_TICKS   = (ACT_WIN_US * 1000) / REF_PERIOD_NS;
   localparam int WIN_W           = 18;
   localparam int DIV_W           = 4;
   localparam int LINE_W          = 12;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0]          regs;
      logic [DIV_W-1:0]                  div_cnt;
      logic [WIN_W-1:0]                  win_cnt;
      logic [NUM_IN-1:0]                 prev;
      logic [NUM_IN-1:0]                 edge_seen;
      logic [NUM_IN-1:0]                 active;
      logic [NUM_IN-1:0][WIN_W-1:0]      hi_cnt;
      logic [NUM_IN-1:0]                 pol_high;
      logic [7:0]                        sep_cnt;
      logic                              sep_out;
      logic                              hs_prev;
      logic                              vs_prev;
      logic [LINE_W-1:0]                 line_cnt;
      logic [LINE_W-1:0]                 frame_lines;
      logic [7:0]                        trail_cnt;
      logic                              trailing;
      logic                              coast_int;
      logic                              hsync_out;
      logic                              vsync_out;
      logic                              clamp_out;
      logic                              coast_out;
      logic [7:0]                        rdata;
   } scc_state_t;
endpackage : scc_pkg

// file: scc_checker.sv
// Concurrent checks on the sync, clamp and coast control bank ports.
// Assumes one clk_sys domain; register shadows follow the decoded write port.
`timescale 1ns/100ps
module scc_checker (
   input wire logic                         clk_sys, // System clock
   input wire logic                         nrst, // Reset, active low
   input wire logic                         reg_wr, // Write strobe
   input wire logic [7:0]                   reg_addr, // Subaddress
   input wire logic [7:0]                   reg_wdata, // Write data
   input wire logic                         coast_in, // External coast pin
   input wire logic                         clamp_in, // External clamp pin
   input wire logic                         clamp_int, // Internal clamp pulse
   input wire logic [2:0]                   fine_clamp_off, // Fine clamp disables
   input wire logic                         fine_clamp_pulse, // Clamp timing out
   input wire logic                         fine_clamp_en, // Fine clamp enable
   input wire logic                         coarse_clamp_en, // Coarse clamp enable
   input wire logic                         adc_ext_clk_sel, // External converter clock
   input wire logic [2:0]                   clamp_mid_level, // Mid level clamp
   input wire logic [scc_pkg::SLICER_W-1:0] slicer_threshold_code, // Slicer code
   input wire logic                         pll_coast, // Coast out
   input wire logic                         pll_phase_update, // Phase tracking
   input wire logic                         pll_freq_hold, // Frequency hold
   input wire logic                         low_power, // Low power state
   input wire logic                         full_power_down, // Power down
   input wire logic [7:0]                   sync_status // Status byte
);
   import scc_pkg::*;
   logic [7:0] sc_ff, pc_ff, sl_ff;

   // Shadows let relations be tied to the programmed fields
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sc_ff <= RST_SYNC_CTL;
         pc_ff <= RST_PLL_CLAMP;
         sl_ff <= RST_SLICER;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_SYNC_CTL) sc_ff <= reg_wdata;
         if (reg_addr == ADDR_PLL_CLAMP) pc_ff <= reg_wdata;
         if (reg_addr == ADDR_SLICER) sl_ff <= reg_wdata;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence coast_ext_s;
      !pc_ff[5] && pc_ff[4];
   endsequence

   power_down_a: assert property (full_power_down == !pc_ff[1])
      else $error("power down wrong");
   test_mode_a: assert property (adc_ext_clk_sel == pc_ff[0] && coarse_clamp_en == pc_ff[0]
      && fine_clamp_en == !pc_ff[0]) else $error("test mode wrong");
   slicer_code_a: assert property (slicer_threshold_code == sl_ff[7:3])
      else $error("slicer code wrong");
   clamp_level_a: assert property (clamp_mid_level == (sl_ff[2:0] & ~fine_clamp_off & {3{!pc_ff[0]}}))
      else $error("clamp level wrong");
   clamp_source_a: assert property (1'b1 |=> fine_clamp_pulse ==
      $past(pc_ff[0] ? 1'b0 : (pc_ff[7] ? clamp_in ^ pc_ff[6] : clamp_int))) else $error("clamp pulse wrong");
   coast_pin_a: assert property (coast_ext_s |=> pll_coast == $past(coast_in ~^ pc_ff[3]))
      else $error("coast pin wrong");
   coast_hold_a: assert property (pll_freq_hold == pll_coast && pll_phase_update == (!pll_coast && pc_ff[1]))
      else $error("pll hold wrong");
   seek_power_a: assert property (low_power == (!pc_ff[2] && !sync_status[7] && !sync_status[4] && !sync_status[1]))
      else $error("low power wrong");
   h_manual_a: assert property (sc_ff[4] |-> sync_status[6] == sc_ff[3])
      else $error("h select wrong");
   h_auto_a: assert property (!sc_ff[4] && sync_status[7] |-> !sync_status[6])
      else $error("h auto wrong");
   v_manual_a: assert property (sc_ff[1] |-> sync_status[3] == sc_ff[0])
      else $error("v select wrong");
   v_auto_a: assert property (!sc_ff[1] && sync_status[4] |-> !sync_status[3])
      else $error("v auto wrong");
endmodule : scc_checker

bind scc_core scc_checker chk_i (.*);

// file: scc_video_src.sv
// Model of a five-wire graphics source: discrete hsync and vsync, sync on green.
// Assumes clk_sys timing; a line is 64 clocks and a frame 8 lines.
`timescale 1ns/100ps
module scc_video_src (
   input  wire logic clk_sys,   // System clock
   input  wire logic nrst,      // Reset, active low
   input  wire logic hs_on,     // Hsync running
   input  wire logic vs_on,     // Vsync running
   input  wire logic sog_on,    // Green sync running
   output logic      hsync_src, // Discrete hsync
   output logic      vsync_src, // Discrete vsync
   output logic      sog_src_n  // Green sync, active low
);
   logic [8:0] pos_ff;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) pos_ff <= 9'h000;
      else pos_ff <= pos_ff + 9'h001;
   end

   // Short high hsync pulses, so its detected polarity is active high; green sync pulses are short and low
   assign hsync_src = hs_on && (pos_ff[5:0] < 6'h08);
   assign sog_src_n = !(sog_on && (pos_ff[5:0] < 6'h08));
   // Vsync starts mid line, clear of any hsync edge
   assign vsync_src = vs_on && (pos_ff >= 9'h020) && (pos_ff < 9'h0A0);
endmodule : scc_video_src

// file: tb.sv
// Self-checking bench for the sync, clamp and coast control bank.
// Assumes scc_pkg, scc_core, the checker and the source model are compiled first.
`timescale 1ns/100ps
module tb;
   import scc_pkg::*;
   localparam int         WIN      = 40;
   localparam int         WIN_CLK  = WIN * REF_DIV;
   localparam logic [7:0] LEAD_RST = 8'h01;
   logic       clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, coast_in = 1'b0, clamp_in = 1'b0;
   logic       clamp_int = 1'b0, raw_bypass = 1'b0, hs_on = 1'b1, vs_on = 1'b1, sog_on = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sync_status;
   logic [2:0] fine_clamp_off = 3'h0, clamp_mid_level;
   logic [4:0] slicer_threshold_code;
   logic       hsync_in, vsync_in, sog_in, hsync_out, vsync_out, fine_clamp_pulse, fine_clamp_en;
   logic       coarse_clamp_en, adc_ext_clk_sel, pll_coast, pll_phase_update, pll_freq_hold;
   logic       low_power, full_power_down;
   int         err_total = 0, cmp_count = 0;
   logic [7:0] rst_tab [NUM_REGS] = '{RST_SYNC_CTL, RST_PLL_CLAMP, RST_SLICER, RST_SEP_THR, LEAD_RST, RST_COAST_TRL};

   always #5 clk_sys = ~clk_sys;

   scc_core #(.ACT_WIN(WIN), .RST_LEAD(LEAD_RST)) uut (.*);
   scc_video_src src (.clk_sys(clk_sys), .nrst(nrst), .hs_on(hs_on), .vs_on(vs_on), .sog_on(sog_on),
      .hsync_src(hsync_in), .vsync_src(vsync_in), .sog_src_n(sog_in));

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      settle(1);
      chk("reg_rdata", reg_rdata, exp);
   endtask : rdchk
   task automatic t_regs();
      settle(0);
      chk("status sources", sync_status & 8'h48, 8'h48);
      for (int i = 0; i < NUM_REGS; i++) begin
         rdchk(ADDR_SYNC_CTL + 8'(i), rst_tab[i]);
         wr(ADDR_SYNC_CTL + 8'(i), 8'hA5 ^ 8'(i));
      end
      for (int i = 0; i < NUM_REGS; i++) begin
         rdchk(ADDR_SYNC_CTL + 8'(i), 8'hA5 ^ 8'(i));
         wr(ADDR_SYNC_CTL + 8'(i), rst_tab[i]);
      end
      wr(8'h30, 8'hFF);
      rdchk(8'h30, 8'h00);
   endtask : t_regs
   task automatic t_clamp();
      wr(ADDR_SLICER, 8'hFF);
      fine_clamp_off <= 3'b010;
      settle(0);
      chk("slicer code", 8'(slicer_threshold_code), 8'h1F);
      chk("mid level", 8'(clamp_mid_level), 8'h05);
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP | {k[1:0], 6'h00});
         clamp_in  <= k[2];
         clamp_int <= ~k[2];
         settle(2);
         chk("clamp pulse", 8'(fine_clamp_pulse), 8'(k[1] ? k[2] ^ k[0] : !k[2]));
      end
      wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP | 8'h01);
      settle(1);
      chk("test clamp", {fine_clamp_en, coarse_clamp_en, adc_ext_clk_sel, fine_clamp_pulse, 1'b0, clamp_mid_level}, 8'h60);
      wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP);
      wr(ADDR_SLICER, RST_SLICER);
   endtask : t_clamp
   task automatic t_coast();
      wr(ADDR_PLL_CLAMP, 8'h16);
      coast_in <= 1'b1;
      settle(2);
      chk("coast pin low", 8'(pll_coast), 8'h00);
      wr(ADDR_PLL_CLAMP, 8'h1E);
      settle(2);
      chk("coast pin high", 8'(pll_coast), 8'h01);
      wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP);
      wr(ADDR_SYNC_CTL, 8'h12);
      wr(ADDR_COAST_TRL, 8'h02);
      repeat (4) @(posedge vsync_in);
      settle(0);
      chk("coast lead", 8'({pll_coast, pll_freq_hold, pll_phase_update}), 8'h06);
      @(negedge vsync_in);
      @(posedge hsync_in);
      settle(2);
      chk("coast trail", 8'(pll_coast), 8'h01);
      repeat (2) @(posedge hsync_in);
      settle(2);
      chk("coast end", 8'(pll_coast), 8'h00);
   endtask : t_coast
   task automatic t_sync_out();
      @(negedge vsync_in);
      settle(3);
      chk("idle low", 8'({hsync_out, vsync_out}), 8'h03);
      wr(ADDR_SYNC_CTL, 8'h36);
      @(negedge vsync_in);
      settle(3);
      chk("idle high", 8'({hsync_out, vsync_out}), 8'h00);
      wr(ADDR_SYNC_CTL, 8'h12);
      raw_bypass <= 1'b1;
      @(posedge hsync_in);
      settle(1);
      chk("raw bypass", 8'(hsync_out), 8'h01);
   endtask : t_sync_out
   task automatic t_auto();
      @(posedge clk_sys);
      raw_bypass <= 1'b0;
      wr(ADDR_SYNC_CTL, 8'h49);
      settle(3 * WIN_CLK);
      chk("auto both", sync_status & 8'hFA, 8'hB2);
      @(posedge clk_sys);
      hs_on <= 1'b0;
      settle(3 * WIN_CLK);
      chk("auto green", sync_status & 8'hDA, 8'h52);
      @(posedge clk_sys);
      vs_on  <= 1'b0;
      sog_on <= 1'b0;
      wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP & 8'hFB);
      settle(3 * WIN_CLK);
      chk("seek idle", 8'({low_power, sync_status[7], sync_status[4], sync_status[1]}), 8'h08);
      wr(ADDR_PLL_CLAMP, RST_PLL_CLAMP);
      settle(0);
      chk("seek off", 8'(low_power), 8'h00);
   endtask : t_auto
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs();
      t_clamp();
      t_coast();
      t_sync_out();
      t_auto();
      finish_test();
   end
   // Run needs about 10k cycles; a hang is cut at 40k
   initial begin
      #400000;
      err_total++;
      finish_test();
   end
endmodule : tb
